/* pll_ctrl.sv */
// loop control registers, charge pump drive and reference buffer power gating
//
// Behaviour
// - A three-bit mode field sets the pump to high impedance, normal locking, forced up or forced down.
// - A three-bit current field gives eight pump current steps scaled by the set resistor.
// - A two-bit field sets the antibacklash pulse width of the phase detector.
// - The detector compares reference and feedback divider edges and commands pump up or down.
// - Software picks one differential or two single-ended references and the block routes accordingly.
// - All reference buffers are off after power-up until software enables one.
// - The differential buffer is off when the loop is down or differential mode is not selected.
// - Each single-ended buffer is off when the loop is down or its own power-down bit is set.
// - Differential mode forces both single-ended buffers off.
// - Detector polarity acts only when the external oscillator is selected.
// - Software selects the on-chip or external oscillator as the feedback source.
// - The polarity bit clear means positive, set means negative polarity.
// - Loop power code 00b runs the loop and 01b powers it down.
// - Staged settings become active only when software writes one to the update register.
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"
module pll_ctrl
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              ref_div_i,
  input  wire logic              fb_div_i,
  output logic                   pump_up_o,
  output logic                   pump_down_o,
  output logic                   pump_hiz_o,
  output logic [2:0]             pump_current_o,
  output logic [1:0]             antibacklash_o,
  output logic                   loop_power_down_o,
  output logic                   diff_ref_power_o,
  output logic                   first_se_power_o,
  output logic                   second_se_power_o,
  output logic                   feedback_external_o
);
  import pll_ctrl_pkg::*;

  if (ADDR_W < 12)
  begin : g_bad_addr
    $error("pll_ctrl: address bus too narrow for the register map");
  end

  ctrl_state_s st_reg;
  ctrl_state_s st_next;
  pfd_if       pfd ();

  logic        acc;
  logic        wr_fire;
  logic [9:0]  idx;
  logic        mapped;
  logic [31:0] rd_word;
  logic        upd_fire;
  logic        loop_on;
  logic        neg_pol;
  logic        det_up;
  logic        det_down;
  logic        addr_high;

  // ***********************************************
  // phase detector
  // ***********************************************
  pfd_core #(
    .ABL_W (2)
  ) u_pfd (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .ref_div_i (ref_div_i),
    .fb_div_i  (fb_div_i),
    .pfd       (pfd.core)
  );

  assign pfd.en  = loop_on;
  assign pfd.abl = st_reg.act_det[`DET_ABL];

  // ***********************************************
  // address bits above the register map
  // ***********************************************
  if (ADDR_W > 12)
  begin : g_addr_high
    assign addr_high = |paddr_i[ADDR_W-1:12];
  end
  else
  begin : g_addr_exact
    assign addr_high = 1'b0;
  end

  // ***********************************************
  // bus decode and read mux
  // ***********************************************
  always_comb
  begin
    idx     = paddr_i[11:2];
    acc     = psel_i & penable_i & ~st_reg.pready;
    wr_fire = psel_i & penable_i & st_reg.pready & pwrite_i & ~st_reg.pslverr;
    mapped  = 1'b1;
    rd_word = `RST_WORD;
    case (idx)
      `IDX_LOOP:   rd_word[7:0] = st_reg.stg_loop;
      `IDX_DET:    rd_word[7:0] = st_reg.stg_det;
      `IDX_REF:    rd_word[7:0] = st_reg.stg_ref;
      `IDX_OSC:    rd_word[7:0] = st_reg.stg_osc;
      `IDX_UPDATE: rd_word[7:0] = 8'h00;
      `IDX_STATUS: rd_word[7:0] = {st_reg.ext, st_reg.loop_pd, st_reg.hiz,
                                   st_reg.down, st_reg.up, st_reg.se2_pw,
                                   st_reg.se1_pw, st_reg.diff_pw};
      default:     mapped = 1'b0;
    endcase
    if (paddr_i[1:0] != 2'h0 || addr_high)
      mapped = 1'b0;
    upd_fire = wr_fire && idx == `IDX_UPDATE
               && pwdata_i[`UPD_FIELD] == `UPDATE_GO;
  end

  // ***********************************************
  // derived loop controls from the active copy
  // ***********************************************
  always_comb
  begin
    loop_on  = st_reg.act_loop[`LOOP_PWR] == `PWR_ON;
    // polarity only swaps the pump sense on the external oscillator
    neg_pol  = st_reg.act_loop[`LOOP_POL] & st_reg.act_osc[`OSC_EXT];
    det_up   = neg_pol ? pfd.down : pfd.up;
    det_down = neg_pol ? pfd.up : pfd.down;
  end

  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    st_next = st_reg;

    // bus answer: one wait cycle, then pready for one cycle
    st_next.pready  = acc;
    st_next.pslverr = acc & ~mapped;
    if (acc)
      st_next.prdata = (mapped && !pwrite_i) ? rd_word : `RST_WORD;

    if (wr_fire)
    begin
      case (idx)
        `IDX_LOOP: st_next.stg_loop = pwdata_i[7:0];
        `IDX_DET:  st_next.stg_det  = pwdata_i[7:0];
        `IDX_REF:  st_next.stg_ref  = pwdata_i[7:0];
        `IDX_OSC:  st_next.stg_osc  = pwdata_i[7:0];
        default:   st_next.stg_loop = st_reg.stg_loop;
      endcase
    end

    if (upd_fire)
    begin
      st_next.act_loop = st_reg.stg_loop;
      st_next.act_det  = st_reg.stg_det;
      st_next.act_ref  = st_reg.stg_ref;
      st_next.act_osc  = st_reg.stg_osc;
    end

    // charge pump drive
    st_next.cur = st_reg.act_det[`DET_CUR];
    st_next.abl = st_reg.act_det[`DET_ABL];
    st_next.up   = 1'b0;
    st_next.down = 1'b0;
    st_next.hiz  = 1'b0;
    if (!loop_on)
      st_next.hiz = 1'b1;
    else
    begin
      case (st_reg.act_loop[`LOOP_CPM])
        `CPM_NORMAL:
        begin
          st_next.up   = det_up;
          st_next.down = det_down;
        end
        `CPM_UP:   st_next.up   = 1'b1;
        `CPM_DOWN: st_next.down = 1'b1;
        default:   st_next.hiz  = 1'b1;
      endcase
    end

    // reference routing and buffer power
    st_next.loop_pd = ~loop_on;
    st_next.ext     = st_reg.act_osc[`OSC_EXT];
    st_next.diff_pw = loop_on & st_reg.act_ref[`REF_DIFF];
    st_next.se1_pw  = loop_on & ~st_reg.act_ref[`REF_DIFF]
                      & ~st_reg.act_ref[`REF_SE1_PD];
    st_next.se2_pw  = loop_on & ~st_reg.act_ref[`REF_DIFF]
                      & ~st_reg.act_ref[`REF_SE2_PD];
  end

  // ***********************************************
  // state register
  // ***********************************************
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      st_reg          <= '0;
      // loop down and both single-ended buffers down: every buffer off
      st_reg.stg_loop <= `RST_LOOP;
      st_reg.stg_det  <= `RST_DET;
      st_reg.stg_ref  <= `RST_REF;
      st_reg.stg_osc  <= `RST_OSC;
      st_reg.act_loop <= `RST_LOOP;
      st_reg.act_det  <= `RST_DET;
      st_reg.act_ref  <= `RST_REF;
      st_reg.act_osc  <= `RST_OSC;
      st_reg.loop_pd  <= 1'b1;
      st_reg.hiz      <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign prdata_o            = st_reg.prdata;
  assign pready_o            = st_reg.pready;
  assign pslverr_o           = st_reg.pslverr;
  assign pump_up_o           = st_reg.up;
  assign pump_down_o         = st_reg.down;
  assign pump_hiz_o          = st_reg.hiz;
  assign pump_current_o      = st_reg.cur;
  assign antibacklash_o      = st_reg.abl;
  assign loop_power_down_o   = st_reg.loop_pd;
  assign diff_ref_power_o    = st_reg.diff_pw;
  assign first_se_power_o    = st_reg.se1_pw;
  assign second_se_power_o   = st_reg.se2_pw;
  assign feedback_external_o = st_reg.ext;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence

  sequence s_update;
    upd_fire;
  endsequence

  AST_APB_ONE_WAIT: assert property (s_setup ##1 s_access |=> pready_o)
    else $error("bus answer not given one cycle into the access phase");

  AST_UPDATE_LOADS: assert property (s_update |=>
    st_reg.act_loop == $past(st_reg.stg_loop) && st_reg.act_ref == $past(st_reg.stg_ref))
    else $error("update did not load staged settings");

  AST_HOLD_WITHOUT_UPDATE: assert property (!upd_fire |=>
    $stable(st_reg.act_loop) && $stable(st_reg.act_ref) && $stable(st_reg.act_osc))
    else $error("active settings changed without update");

  AST_DIFF_OFF_LOOP_DOWN: assert property (!loop_on |=> !diff_ref_power_o)
    else $error("differential buffer on while loop is down");

  AST_DIFF_NEEDS_SELECT: assert property (!st_reg.act_ref[`REF_DIFF] |=> !diff_ref_power_o)
    else $error("differential buffer on without differential mode");

  AST_SE_FORCED_OFF: assert property (st_reg.act_ref[`REF_DIFF]
    |=> !first_se_power_o && !second_se_power_o)
    else $error("single-ended buffer on in differential mode");

  AST_SE_OWN_PD: assert property (loop_on && !st_reg.act_ref[`REF_DIFF]
    |=> first_se_power_o == !$past(st_reg.act_ref[`REF_SE1_PD])
        && second_se_power_o == !$past(st_reg.act_ref[`REF_SE2_PD]))
    else $error("single-ended buffer power does not follow its own bit");

  AST_PUMP_HIZ: assert property (st_reg.act_loop[`LOOP_CPM] == `CPM_HIZ
    |=> pump_hiz_o && !pump_up_o && !pump_down_o)
    else $error("pump not high impedance in hold mode");

  AST_PUMP_FORCED_UP: assert property (loop_on && st_reg.act_loop[`LOOP_CPM] == `CPM_UP
    |=> pump_up_o && !pump_down_o && !pump_hiz_o)
    else $error("pump not forced up");

  AST_POL_IGNORED_INTERNAL: assert property (loop_on
    && st_reg.act_loop[`LOOP_CPM] == `CPM_NORMAL && !st_reg.act_osc[`OSC_EXT]
    |=> pump_up_o == $past(pfd.up) && pump_down_o == $past(pfd.down))
    else $error("polarity acted on the on-chip oscillator");

  AST_POL_NEGATIVE_SWAPS: assert property (loop_on
    && st_reg.act_loop[`LOOP_CPM] == `CPM_NORMAL && neg_pol
    |=> pump_up_o == $past(pfd.down) && pump_down_o == $past(pfd.up))
    else $error("negative polarity did not swap pump sense");

  AST_CURRENT_FOLLOWS: assert property (s_update ##1 1'b1
    |=> pump_current_o == $past(st_reg.act_det[`DET_CUR]))
    else $error("pump current step does not follow the active field");

  sequence s_pump_idle;
    pump_hiz_o && !pump_up_o && !pump_down_o;
  endsequence

  AST_PUMP_FORCED_DOWN: assert property (loop_on
    && st_reg.act_loop[`LOOP_CPM] == `CPM_DOWN
    |=> pump_down_o && !pump_up_o && !pump_hiz_o)
    else $error("pump not forced down");

  AST_LOOP_DOWN_IDLES: assert property (!loop_on
    |=> loop_power_down_o ##0 s_pump_idle)
    else $error("pump not idle while loop is down");

  AST_SE_OFF_LOOP_DOWN: assert property (!loop_on
    |=> !first_se_power_o && !second_se_power_o)
    else $error("single-ended buffer on while loop is down");

  AST_DIFF_ON_SELECTED: assert property (loop_on && st_reg.act_ref[`REF_DIFF]
    |=> diff_ref_power_o)
    else $error("differential buffer off although selected with loop on");

  AST_UPDATE_LOADS_REST: assert property (s_update |=>
    st_reg.act_det == $past(st_reg.stg_det) && st_reg.act_osc == $past(st_reg.stg_osc))
    else $error("update did not load staged detector or oscillator settings");

  AST_ABL_FOLLOWS: assert property (s_update ##1 1'b1
    |=> antibacklash_o == $past(st_reg.act_det[`DET_ABL]))
    else $error("antibacklash code does not follow the active field");

  AST_FEEDBACK_FOLLOWS: assert property (s_update ##1 1'b1
    |=> feedback_external_o == $past(st_reg.act_osc[`OSC_EXT]))
    else $error("feedback source does not follow the active selection");

  AST_APB_UNMAPPED: assert property (s_setup ##1 s_access ##0 !mapped
    |=> pready_o && pslverr_o)
    else $error("unmapped access answered without error");

endmodule // pll_ctrl

/* pll_ctrl_defines.svh */
// register indices, field positions, codes and reset values of the loop control block
`ifndef PLL_CTRL_DEFINES_SVH
`define PLL_CTRL_DEFINES_SVH

// ***********************************************
// register indices (byte address = index * 4)
// ***********************************************
`define IDX_LOOP      10'h010
`define IDX_DET       10'h017
`define IDX_REF       10'h01c
`define IDX_UPDATE    10'h232
`define IDX_OSC       10'h0f0
`define IDX_STATUS    10'h0f1

// ***********************************************
// field positions
// ***********************************************
`define LOOP_PWR      1:0
`define LOOP_CPM      6:4
`define LOOP_POL      7
`define DET_ABL       1:0
`define DET_CUR       4:2
`define REF_DIFF      0
`define REF_SE1_PD    1
`define REF_SE2_PD    2
`define OSC_EXT       0
`define UPD_FIELD     7:0

// ***********************************************
// field codes
// ***********************************************
`define PWR_ON        2'h0
`define PWR_DOWN      2'h1
`define CPM_HIZ       3'h0
`define CPM_UP        3'h1
`define CPM_DOWN      3'h2
`define CPM_NORMAL    3'h3
`define UPDATE_GO     8'h01

// ***********************************************
// reset values
// ***********************************************
`define RST_LOOP      8'h01
`define RST_DET       8'h00
`define RST_REF       8'h06
`define RST_OSC       8'h00
`define RST_WORD      32'h0000_0000

`endif

/* pll_ctrl_pkg.sv */
// state types of the loop control block and its phase detector
package pll_ctrl_pkg;

  typedef struct packed {
    logic [7:0]  stg_loop;
    logic [7:0]  stg_det;
    logic [7:0]  stg_ref;
    logic [7:0]  stg_osc;
    logic [7:0]  act_loop;
    logic [7:0]  act_det;
    logic [7:0]  act_ref;
    logic [7:0]  act_osc;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        up;
    logic        down;
    logic        hiz;
    logic [2:0]  cur;
    logic [1:0]  abl;
    logic        loop_pd;
    logic        diff_pw;
    logic        se1_pw;
    logic        se2_pw;
    logic        ext;
  } ctrl_state_s;

  typedef struct packed {
    logic [1:0] ref_sync;
    logic       ref_last;
    logic [1:0] fb_sync;
    logic       fb_last;
    logic       up;
    logic       down;
    logic [1:0] cnt;
  } pfd_state_s;

endpackage

/* pfd_if.sv */
// link between the loop controller and its phase detector
`timescale 1ns/1ps
interface pfd_if;
  logic       en;
  logic [1:0] abl;
  logic       up;
  logic       down;

  modport ctrl (output en, output abl, input up, input down);
  modport core (input en, input abl, output up, output down);
endinterface

/* pfd_core.sv */
// phase frequency detector with antibacklash hold
`timescale 1ns/1ps
module pfd_core
#(
  parameter int ABL_W = 2
)
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ref_div_i,
  input  wire logic fb_div_i,
  pfd_if.core       pfd
);
  import pll_ctrl_pkg::*;

  if (ABL_W != 2)
  begin : g_bad_width
    $error("pfd_core: antibacklash field must be two bits");
  end

  pfd_state_s st_reg;
  pfd_state_s st_next;
  logic       ref_rise;
  logic       fb_rise;

  // ***********************************************
  // detector
  // ***********************************************
  always_comb
  begin
    st_next            = st_reg;
    st_next.ref_sync   = {st_reg.ref_sync[0], ref_div_i};
    st_next.fb_sync    = {st_reg.fb_sync[0], fb_div_i};
    st_next.ref_last   = st_reg.ref_sync[1];
    st_next.fb_last    = st_reg.fb_sync[1];
    ref_rise           = st_reg.ref_sync[1] & ~st_reg.ref_last;
    fb_rise            = st_reg.fb_sync[1] & ~st_reg.fb_last;
    if (!pfd.en)
    begin
      st_next.up   = 1'b0;
      st_next.down = 1'b0;
      st_next.cnt  = 2'h0;
    end
    else if (st_reg.up && st_reg.down)
    begin
      // both high: hold for abl+1 cycles, then clear together
      if (st_reg.cnt == pfd.abl)
      begin
        st_next.up   = 1'b0;
        st_next.down = 1'b0;
        st_next.cnt  = 2'h0;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 2'h1;
      end
    end
    else
    begin
      st_next.up   = st_reg.up | ref_rise;
      st_next.down = st_reg.down | fb_rise;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign pfd.up   = st_reg.up;
  assign pfd.down = st_reg.down;

  // ***********************************************
  // checks
  // ***********************************************
  AST_PFD_REF_LEADS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pfd.en && !st_reg.up && !st_reg.down && ref_rise && !fb_rise
    |=> st_reg.up && !st_reg.down)
    else $error("reference edge did not raise pump up");

  AST_PFD_PAIR_CLEARS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    pfd.en && st_reg.up && st_reg.down && st_reg.cnt == 2'h0
    |-> ##[1:4] !st_reg.up && !st_reg.down)
    else $error("antibacklash hold did not end in time");

endmodule // pfd_core

/* ref_model.sv */
// reference source and oscillator divider model facing the phase detector
`timescale 1ns/1ps
module ref_model
(
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] ref_half_i,
  input  wire logic [7:0] fb_half_i,
  output logic            ref_div_o,
  output logic            fb_div_o
);
  logic [7:0] ref_cnt;
  logic [7:0] fb_cnt;

  initial
  begin
    ref_div_o = 1'b0;
    fb_div_o  = 1'b0;
    ref_cnt   = 8'h00;
    fb_cnt    = 8'h00;
  end

  // ***********************************************
  // divider outputs
  // ***********************************************
  // both lines keep toggling within a frame and stand still between frames
  always @(posedge clk_i)
  begin
    if (run_i)
    begin
      if (ref_cnt == ref_half_i - 8'h01)
      begin
        ref_cnt   <= 8'h00;
        ref_div_o <= !ref_div_o;
      end
      else
        ref_cnt <= ref_cnt + 8'h01;
      if (fb_cnt == fb_half_i - 8'h01)
      begin
        fb_cnt   <= 8'h00;
        fb_div_o <= !fb_div_o;
      end
      else
        fb_cnt <= fb_cnt + 8'h01;
    end
  end
endmodule // ref_model

/* tb_top.sv */
// self-checking bench of the loop control block
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import pll_ctrl_pkg::*;
  logic        clk_i;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        ref_div;
  logic        fb_div;
  logic        pump_up_o;
  logic        pump_down_o;
  logic        pump_hiz_o;
  logic [2:0]  pump_current_o;
  logic [1:0]  antibacklash_o;
  logic        loop_power_down_o;
  logic        diff_ref_power_o;
  logic        first_se_power_o;
  logic        second_se_power_o;
  logic        feedback_external_o;
  logic        run;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0]  d;
  logic        pd;
  int          seed;
  int          n_errors;
  int          checks_done;
  int          p;
  int          r;
  int          m;
  int          nu;
  int          nd;

  pll_ctrl #(.ADDR_W(12)) pll_ctrl_inst
  (
    .clk_i(clk_i), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ref_div_i(ref_div), .fb_div_i(fb_div),
    .pump_up_o(pump_up_o), .pump_down_o(pump_down_o), .pump_hiz_o(pump_hiz_o),
    .pump_current_o(pump_current_o), .antibacklash_o(antibacklash_o),
    .loop_power_down_o(loop_power_down_o), .diff_ref_power_o(diff_ref_power_o),
    .first_se_power_o(first_se_power_o), .second_se_power_o(second_se_power_o),
    .feedback_external_o(feedback_external_o)
  );

  ref_model ref_model_inst
  (
    .clk_i(clk_i), .run_i(run), .ref_half_i(8'h03), .fb_half_i(8'h07),
    .ref_div_o(ref_div), .fb_div_o(fb_div)
  );

  always #10 clk_i = ~clk_i;

  // ***********************************************
  // bus tasks
  // ***********************************************
  // note: {is_read, error, data}
  task automatic apb(input logic is_wr, input logic [9:0] idx, input logic [7:0] wd,
                     input logic [33:0] note);
    logic [31:0] rnd;
    rnd = $random(seed);
    @(posedge clk_i);
    exp_q.push_back(note);
    psel    <= 1'b1;
    pwrite  <= is_wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= {rnd[31:8], wd};
    @(posedge clk_i);
    penable <= 1'b1;
    // hold the request until pready is seen high at an edge; only the watchdog ends a wait
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 34'h0);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] v);
    apb(1'b0, idx, 8'h00, {2'b10, 24'h0, v});
  endtask

  task automatic upd;
    wr(`IDX_UPDATE, `UPDATE_GO);
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ***********************************************
  // response watcher
  // ***********************************************
  always @(posedge clk_i)
  begin
    if (pready_o === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK(pslverr_o, e[32])
      if (e[33])
        `CHK(prdata_o, e[31:0])
    end
  end

  initial
  begin
    #(20 * 20000);
    n_errors++;
    wrap_up();
  end

  // ***********************************************
  // tests
  // ***********************************************
  initial
  begin
    seed = 65989;
    clk_i = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_i);
    nrst <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK(pump_hiz_o, 1'b1)
    `CHK(loop_power_down_o, 1'b1)
    `CHK({diff_ref_power_o, first_se_power_o, second_se_power_o}, 3'h0)
    rd(`IDX_LOOP, `RST_LOOP);
    rd(`IDX_DET, `RST_DET);
    rd(`IDX_REF, `RST_REF);
    rd(`IDX_OSC, `RST_OSC);
    apb(1'b0, 10'h011, 8'h00, {2'b11, 32'h0});
    $display("test reset and map done");
    wr(`IDX_LOOP, 8'h30);
    wr(`IDX_REF, 8'h01);
    wr(`IDX_UPDATE, 8'h02);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK({loop_power_down_o, diff_ref_power_o}, 2'b10)
    rd(`IDX_LOOP, 8'h30);
    upd();
    `CHK({loop_power_down_o, diff_ref_power_o}, 2'b01)
    rd(`IDX_STATUS, 8'h01);
    $display("test staging done");
    for (p = 0; p < 4; p++)
      for (r = 0; r < 8; r++)
      begin
        wr(`IDX_LOOP, {2'b00, 2'b11, 2'b00, p[1:0]});
        wr(`IDX_REF, r[7:0]);
        upd();
        pd = (p != 0);
        `CHK(loop_power_down_o, pd)
        `CHK(pump_hiz_o, pd)
        `CHK(diff_ref_power_o, !pd && r[0])
        `CHK(first_se_power_o, !pd && !r[0] && !r[1])
        `CHK(second_se_power_o, !pd && !r[0] && !r[2])
      end
    $display("test buffer power done");
    for (m = 0; m < 8; m++)
    begin
      d = 8'($random(seed));
      wr(`IDX_LOOP, {1'b0, m[2:0], 4'h0});
      wr(`IDX_DET, {3'h0, d[4:0]});
      upd();
      `CHK(pump_hiz_o, !(m >= 1 && m <= 3))
      `CHK(pump_up_o, m == 1)
      `CHK(pump_down_o, m == 2)
      `CHK(pump_current_o, d[4:2])
      `CHK(antibacklash_o, d[1:0])
      rd(`IDX_DET, {3'h0, d[4:0]});
    end
    $display("test pump modes done");
    for (m = 0; m < 4; m++)
    begin
      wr(`IDX_OSC, {7'h0, m[1]});
      wr(`IDX_LOOP, {m[0], 3'h3, 4'h0});
      upd();
      `CHK(feedback_external_o, m[1])
      run <= 1'b1;
      nu = 0;
      nd = 0;
      repeat (400)
      begin
        @(posedge clk_i);
        nu += pump_up_o;
        nd += pump_down_o;
      end
      run <= 1'b0;
      `CHK(nu > nd, !(m[1] && m[0]))
    end
    $display("test detector done");
    wrap_up();
  end
endmodule // tb_top
